// [hdl/pmsil_top.v]
`timescale 1ns/1ns
`include "pmsil_consts.vh"
// What this block does
// - Sixteen-bit registers, standard low, vendor high
// - Answer own address and broadcast zero
// - Broadcast zero allows shared write only, never read
// - Strap or control bit disables broadcast
// - Address strap caught at reset release
// - Address, register, turnaround, data, release
// - Interrupt when enabled status condition updates
// - High byte enables interrupt conditions
// - Low byte records occurred conditions
// - Reading status register clears status
// - Polarity bit, active low after reset
// - Auto crossover on, off by bit
// - Forced MDI or MDI-X when off
// - Auto mode follows sensed partner pairs
// - MDI transmits first pair, MDI-X swaps
// - Local loopback MAC side, full duplex
// - Remote loopback only at 100 full
module pmsil_top (
    input  wire        clk_i,          // 125 MHz system clock
    input  wire        srst_i,         // Sync reset, active high
    input  wire        mgmt_clk_i,     // Management clock pin
    input  wire        mgmt_data_i,    // Data line level in
    output reg         mgmt_data_o,    // Data line drive value
    output reg         mgmt_data_oe_o, // High while driving
    input  wire [2:0]  address_strap_i, // Unique address strap
    input  wire        broadcast_disable_strap_i, // Broadcast off strap
    input  wire [7:0]  irq_event_i,    // Status condition pulses
    input  wire        partner_mdix_i, // Sensed partner is MDI-X
    output reg         interrupt_pin_o, // Interrupt pin level
    output reg         pair_swap_o,    // 1: MDI-X pairs
    output reg         local_loop_o,   // MAC-side loopback on
    output reg         remote_loop_o,  // Line-side loopback on
    output reg         speed_100_o,    // Speed select
    output reg         full_duplex_o   // Duplex select
);
    localparam ST_IDLE = 3'd0;
    localparam ST_PRE  = 3'd1;
    localparam ST_HDR  = 3'd2;
    localparam ST_TA   = 3'd3;
    localparam ST_RD   = 3'd4;
    localparam ST_WR   = 3'd5;

    wire mdc_s;
    wire mdi_s;
    pmsil_sync u_sync_clk (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    (mgmt_clk_i),
        .q_o    (mdc_s)
    );
    pmsil_sync u_sync_dat (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    (mgmt_data_i),
        .q_o    (mdi_s)
    );

    reg        mdc_d_r;
    reg        rst_d_r;
    reg  [2:0] phy_addr_r;
    reg        bc_strap_r;
    reg  [2:0] state_r;
    reg  [5:0] pre_cnt_r;
    reg  [4:0] bit_cnt_r;
    reg [13:0] hdr_r;
    reg [15:0] shift_r;
    reg        rd_sel_r;
    reg [15:0] bctl_r;
    reg [15:0] ovr_r;
    reg  [7:0] ien_r;
    reg  [7:0] ists_r;
    reg [15:0] pc2_r;

    wire rise = mdc_s & ~mdc_d_r;
    wire fall = ~mdc_s & mdc_d_r;

    // Fields of the captured header: start, op, addr, reg
    wire [1:0] h_st  = hdr_r[13:12];
    wire [1:0] h_op  = hdr_r[11:10];
    wire [4:0] h_pa  = hdr_r[9:5];
    wire [4:0] h_ra  = hdr_r[4:0];

    function addr_hit;
        input [4:0] pa;
        input [2:0] own;
        input       bc_on;
        begin
            addr_hit = (pa[4:3] == `PMSIL_ADDR_HI) &&
                       ((pa[2:0] == own) ||
                        (bc_on && pa[2:0] == `PMSIL_BCAST_ADDR));
        end
    endfunction

    wire bc_on = ~bc_strap_r & ~ovr_r[`PMSIL_OVR_BCOFF];
    wire hit   = addr_hit(h_pa, phy_addr_r, bc_on);
    // Broadcast reads would collide on a shared line; only own-address
    // match drives, so a single device can still be read at 0
    wire rd_ok = hit && (h_pa[2:0] == phy_addr_r);
    wire wr_ok = hit;

    function [15:0] reg_read;
        input [4:0]  ra;
        input [15:0] bctl;
        input [15:0] ovr;
        input [7:0]  ien;
        input [7:0]  ists;
        input [15:0] pc2;
        begin
            case (ra)
                `PMSIL_REG_BCTL: reg_read = bctl;
                `PMSIL_REG_OVR:  reg_read = ovr;
                `PMSIL_REG_ICS:  reg_read = {ien, ists};
                `PMSIL_REG_PC2:  reg_read = pc2;
                default:         reg_read = `PMSIL_READ_ZERO;
            endcase
        end
    endfunction

    // Strap caught one cycle after reset release, never under reset
    always @(posedge clk_i) begin
        rst_d_r <= srst_i;
        if (rst_d_r && !srst_i) begin
            phy_addr_r <= address_strap_i;
            bc_strap_r <= broadcast_disable_strap_i;
        end
    end

    // Count starts with the turnaround bit, so D0 lands at sixteen
    wire wr_done = (state_r == ST_WR) && rise &&
                   (bit_cnt_r == `PMSIL_DATA_BITS) && wr_ok;
    wire [15:0] wr_data = {shift_r[14:0], mdi_s};
    wire ics_rd = (state_r == ST_TA) && rise &&
                  (h_op == `PMSIL_OP_RD) && rd_ok &&
                  (h_ra == `PMSIL_REG_ICS);

    always @(posedge clk_i) begin
        if (srst_i) begin
            mdc_d_r        <= 1'b0;
            state_r        <= ST_IDLE;
            pre_cnt_r      <= 6'd0;
            bit_cnt_r      <= 5'd0;
            hdr_r          <= 14'd0;
            shift_r        <= 16'd0;
            rd_sel_r       <= 1'b0;
            mgmt_data_o    <= 1'b0;
            mgmt_data_oe_o <= 1'b0;
        end else begin
            mdc_d_r <= mdc_s;
            if (rise) begin
                case (state_r)
                    ST_IDLE, ST_PRE: begin
                        if (mdi_s) begin
                            if (pre_cnt_r != `PMSIL_PRE_LEN)
                                pre_cnt_r <= pre_cnt_r + 6'd1;
                            state_r <= ST_PRE;
                        end else if (pre_cnt_r == `PMSIL_PRE_LEN) begin
                            hdr_r     <= 14'd0;
                            bit_cnt_r <= 5'd1;
                            state_r   <= ST_HDR;
                        end else begin
                            pre_cnt_r <= 6'd0;
                            state_r   <= ST_IDLE;
                        end
                    end
                    ST_HDR: begin
                        hdr_r     <= {hdr_r[12:0], mdi_s};
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        if (bit_cnt_r == `PMSIL_HDR_BITS - 5'd1)
                            state_r <= ST_TA;
                    end
                    ST_TA: begin
                        pre_cnt_r <= 6'd0;
                        bit_cnt_r <= 5'd0;
                        if (h_st != 2'b01) begin
                            state_r <= ST_IDLE;
                        end else if (h_op == `PMSIL_OP_RD) begin
                            rd_sel_r <= rd_ok;
                            shift_r  <= reg_read(h_ra, bctl_r, ovr_r,
                                                 ien_r, ists_r, pc2_r);
                            state_r  <= ST_RD;
                        end else if (h_op == `PMSIL_OP_WR) begin
                            state_r  <= ST_WR;
                        end else begin
                            state_r  <= ST_IDLE;
                        end
                    end
                    ST_RD: begin
                        // Stay until D0 is sampled so its bit is driven
                        if (bit_cnt_r == `PMSIL_DATA_BITS)
                            state_r <= ST_IDLE;
                        else
                            bit_cnt_r <= bit_cnt_r + 5'd1;
                    end
                    ST_WR: begin
                        // Second turnaround bit arrives first here
                        shift_r   <= {shift_r[14:0], mdi_s};
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        if (bit_cnt_r == `PMSIL_DATA_BITS)
                            state_r <= ST_IDLE;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
            // Drive on falling edge so the controller samples on rising
            if (fall) begin
                if (state_r == ST_RD && rd_sel_r) begin
                    mgmt_data_oe_o <= 1'b1;
                    if (bit_cnt_r == 5'd0) begin
                        mgmt_data_o <= 1'b0;
                    end else begin
                        mgmt_data_o <= shift_r[15];
                        shift_r     <= {shift_r[14:0], 1'b0};
                    end
                end else begin
                    mgmt_data_oe_o <= 1'b0;
                    mgmt_data_o    <= 1'b0;
                end
            end
        end
    end

    // Register file and status
    integer i;
    always @(posedge clk_i) begin
        if (srst_i) begin
            bctl_r <= `PMSIL_BCTL_RST;
            ovr_r  <= `PMSIL_OVR_RST;
            ien_r  <= `PMSIL_ICS_RST;
            ists_r <= `PMSIL_ICS_RST;
            pc2_r  <= `PMSIL_PC2_RST;
        end else begin
            if (wr_done) begin
                case (h_ra)
                    `PMSIL_REG_BCTL: bctl_r <= wr_data;
                    `PMSIL_REG_OVR:  ovr_r  <= wr_data;
                    `PMSIL_REG_ICS:  ien_r  <= wr_data[15:8];
                    `PMSIL_REG_PC2:  pc2_r  <= wr_data;
                    default: ;
                endcase
            end
            // Set wins over the read clear
            for (i = 0; i < 8; i = i + 1) begin
                if (irq_event_i[i])
                    ists_r[i] <= 1'b1;
                else if (ics_rd)
                    ists_r[i] <= 1'b0;
            end
        end
    end

    wire irq_act = |(ists_r & ien_r);
    wire fd_100  = bctl_r[`PMSIL_BCTL_SPEED] &
                   bctl_r[`PMSIL_BCTL_DUPLEX];

    always @(posedge clk_i) begin
        if (srst_i) begin
            interrupt_pin_o <= 1'b1;
            pair_swap_o     <= 1'b0;
            local_loop_o    <= 1'b0;
            remote_loop_o   <= 1'b0;
            speed_100_o     <= 1'b1;
            full_duplex_o   <= 1'b1;
        end else begin
            // Polarity bit high selects active high
            interrupt_pin_o <= pc2_r[`PMSIL_PC2_IPOL] ? irq_act
                                                      : ~irq_act;
            if (pc2_r[`PMSIL_PC2_AUTOOFF])
                pair_swap_o <= pc2_r[`PMSIL_PC2_MDIX];
            else
                // Partner MDI-X means we take MDI, else swap
                pair_swap_o <= ~partner_mdix_i;
            local_loop_o  <= bctl_r[`PMSIL_BCTL_LOOP] &
                             bctl_r[`PMSIL_BCTL_DUPLEX];
            remote_loop_o <= pc2_r[`PMSIL_PC2_RLOOP] & fd_100;
            speed_100_o   <= bctl_r[`PMSIL_BCTL_SPEED];
            full_duplex_o <= bctl_r[`PMSIL_BCTL_DUPLEX];
        end
    end
endmodule

// [hdl/pmsil_consts.vh]
`ifndef PMSIL_CONSTS_VH
`define PMSIL_CONSTS_VH
// Register addresses
`define PMSIL_REG_BCTL      5'h00
`define PMSIL_REG_OVR       5'h16
`define PMSIL_REG_ICS       5'h1b
`define PMSIL_REG_PC2       5'h1f
// Field positions
`define PMSIL_BCTL_LOOP     14
`define PMSIL_BCTL_SPEED    13
`define PMSIL_BCTL_ANEG     12
`define PMSIL_BCTL_DUPLEX   8
`define PMSIL_OVR_BCOFF     9
`define PMSIL_PC2_MDIX      14
`define PMSIL_PC2_AUTOOFF   13
`define PMSIL_PC2_IPOL      9
`define PMSIL_PC2_RLOOP     2
// Reset values
`define PMSIL_BCTL_RST      16'h3100
`define PMSIL_OVR_RST       16'h0000
`define PMSIL_ICS_RST       8'h00
`define PMSIL_PC2_RST       16'h0000
// Frame format
`define PMSIL_PRE_LEN       6'd32
`define PMSIL_HDR_BITS      5'd14
`define PMSIL_TA_BIT        5'd15
`define PMSIL_DATA_BITS     5'd16
`define PMSIL_OP_RD         2'b10
`define PMSIL_OP_WR         2'b01
`define PMSIL_BCAST_ADDR    3'h0
`define PMSIL_ADDR_HI       2'b00
`define PMSIL_READ_ZERO     16'h0000
`endif

// [hdl/pmsil_sync.v]
`timescale 1ns/1ns
// Two-stage synchroniser; first stage feeds only the second
module pmsil_sync (
    input  wire       clk_i,    // System clock
    input  wire       srst_i,   // Sync reset
    input  wire       d_i,      // Async input
    output reg        q_o       // Synchronised
);
    reg meta_r;

    always @(posedge clk_i) begin
        if (srst_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// [dv/pmsil_assertions.sv]
`timescale 1ns/1ns
module pmsil_assertions (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic       mgmt_clk_i,
    input wire logic       mgmt_data_i,
    input wire logic       mgmt_data_o,
    input wire logic       mgmt_data_oe_o,
    input wire logic [2:0] address_strap_i,
    input wire logic       broadcast_disable_strap_i,
    input wire logic [7:0] irq_event_i,
    input wire logic       partner_mdix_i,
    input wire logic       interrupt_pin_o,
    input wire logic       pair_swap_o,
    input wire logic       local_loop_o,
    input wire logic       remote_loop_o,
    input wire logic       speed_100_o,
    input wire logic       full_duplex_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [8:0] oe_cnt;
    logic [5:0] idle_cnt;
    logic [3:0] ev_w;
    logic [3:0] sw_w;
    logic       clk_q;
    logic       mdix_q;
    // Windows also swallow reset so outputs may settle after release
    always @(posedge clk_i) begin
        clk_q <= mgmt_clk_i;
        mdix_q <= partner_mdix_i;
        ev_w <= {ev_w[2:0], srst_i | (|irq_event_i)};
        sw_w <= {sw_w[2:0], srst_i | (partner_mdix_i != mdix_q)};
        if (srst_i || !mgmt_data_oe_o)
            oe_cnt <= 9'h0;
        else
            oe_cnt <= oe_cnt + 9'h1;
        if (srst_i || clk_q != mgmt_clk_i)
            idle_cnt <= 6'h0;
        else if (idle_cnt != 6'h3f)
            idle_cnt <= idle_cnt + 6'h1;
    end
    sequence s_ta_zero;
        (mgmt_data_oe_o && !mgmt_data_o) [*8];
    endsequence
    chk_ta_low: assert property ($rose(mgmt_data_oe_o) |-> s_ta_zero)
        else $error("turnaround bit not driven low");
    chk_drive_len: assert property ($fell(mgmt_data_oe_o) |->
        oe_cnt >= 9'h104 && oe_cnt <= 9'h110)
        else $error("drive window not seventeen bits");
    chk_low_phase: assert property (($changed(mgmt_data_o) ||
        $changed(mgmt_data_oe_o)) |-> !mgmt_clk_i)
        else $error("data moved in high clock phase");
    chk_drive_idle: assert property (mgmt_data_oe_o |-> idle_cnt < 6'h28)
        else $error("driving with clock stopped");
    chk_remote_gate: assert property (remote_loop_o |->
        speed_100_o && full_duplex_o)
        else $error("remote loop outside 100 full");
    chk_local_fdx: assert property (local_loop_o |-> full_duplex_o)
        else $error("local loop in half duplex");
    chk_irq_cause: assert property ($changed(interrupt_pin_o) |->
        (|ev_w) || idle_cnt < 6'h28)
        else $error("interrupt moved without cause");
    chk_swap_cause: assert property ($changed(pair_swap_o) |->
        (|sw_w) || idle_cnt < 6'h28)
        else $error("pair swap moved without cause");
endmodule
bind pmsil_top pmsil_assertions u_pmsil_assertions (
    .clk_i(clk_i), .srst_i(srst_i), .mgmt_clk_i(mgmt_clk_i),
    .mgmt_data_i(mgmt_data_i), .mgmt_data_o(mgmt_data_o),
    .mgmt_data_oe_o(mgmt_data_oe_o), .address_strap_i(address_strap_i),
    .broadcast_disable_strap_i(broadcast_disable_strap_i),
    .irq_event_i(irq_event_i), .partner_mdix_i(partner_mdix_i),
    .interrupt_pin_o(interrupt_pin_o), .pair_swap_o(pair_swap_o),
    .local_loop_o(local_loop_o), .remote_loop_o(remote_loop_o),
    .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o));

// [dv/pmsil_mac_model.sv]
`timescale 1ns/1ns
module pmsil_mac_model (
    output logic mgmt_clk_o, // Management clock
    output logic md_o,       // Data drive value
    output logic md_oe_o,    // High while driving
    input  wire  md_i        // Resolved line level
);
    initial begin
        mgmt_clk_o = 1'b0;
        md_o = 1'b0;
        md_oe_o = 1'b0;
    end
    // 125 ns period; clock stands low between frames
    task automatic tick(input logic oe, input logic b, output logic s);
        mgmt_clk_o = 1'b0;
        md_oe_o = oe;
        md_o = b;
        #62;
        mgmt_clk_o = 1'b1;
        s = md_i;
        #63;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [16:0] rd);
        logic [63:0] bits;
        logic        s;
        bits = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            tick(i > 17 || op == 2'b01, bits[i], s);
            if (i < 17)
                rd[i] = s;
        end
        mgmt_clk_o = 1'b0;
        md_oe_o = 1'b0;
        #125;
    endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin \
    n_errors++; $display("ERROR %0t %s", $time, m); end end
module testbench;
    logic       clk_i;
    logic       srst_i;
    logic [7:0] irq_event_i;
    logic       partner_mdix_i;
    wire        mdc;
    wire        mac_d;
    wire        mac_oe;
    wire        dut_d;
    wire        dut_oe;
    wire        ipin;
    wire        swp;
    wire        lloop;
    wire        rloop;
    wire        spd;
    wire        fdx;
    int         n_errors = 0;
    int         num_checks = 0;
    // Released line floats high through the pull-up
    wire        mdio = dut_oe ? dut_d : (mac_oe ? mac_d : 1'b1);
    pmsil_top u_pmsil_top (.clk_i(clk_i), .srst_i(srst_i),
        .mgmt_clk_i(mdc), .mgmt_data_i(mdio), .mgmt_data_o(dut_d),
        .mgmt_data_oe_o(dut_oe), .address_strap_i(3'h5),
        .broadcast_disable_strap_i(1'b0), .irq_event_i(irq_event_i),
        .partner_mdix_i(partner_mdix_i), .interrupt_pin_o(ipin),
        .pair_swap_o(swp), .local_loop_o(lloop), .remote_loop_o(rloop),
        .speed_100_o(spd), .full_duplex_o(fdx));
    pmsil_mac_model u_pmsil_mac_model (.mgmt_clk_o(mdc), .md_o(mac_d),
        .md_oe_o(mac_oe), .md_i(mdio));
    task automatic wr(input logic [4:0] pa, ra, input logic [15:0] d);
        logic [16:0] r;
        u_pmsil_mac_model.frame(2'b01, pa, ra, d, r);
    endtask
    task automatic rd(input logic [4:0] pa, ra, input logic [16:0] e);
        logic [16:0] r;
        u_pmsil_mac_model.frame(2'b10, pa, ra, 16'h0, r);
        `CHK(r, e, "read data")
    endtask
    task automatic ev(input logic [7:0] e);
        @(posedge clk_i);
        #1 irq_event_i = e;
        @(posedge clk_i);
        #1 irq_event_i = 8'h0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #600000;
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim;
    end
    initial begin
        srst_i = 1'b1;
        irq_event_i = 8'h0;
        partner_mdix_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK(ipin, 1'b1, "interrupt idle level")
        `CHK(swp, 1'b1, "auto pair choice")
        rd(5'h05, 5'h00, 17'h03100);
        rd(5'h03, 5'h00, 17'h1ffff);
        rd(5'h0d, 5'h00, 17'h1ffff);
        rd(5'h00, 5'h00, 17'h1ffff);
        wr(5'h00, 5'h1f, 16'h6000);
        rd(5'h05, 5'h1f, 17'h06000);
        `CHK(swp, 1'b1, "forced crossed pairs")
        wr(5'h05, 5'h1f, 16'h2000);
        `CHK(swp, 1'b0, "forced straight pairs")
        wr(5'h05, 5'h16, 16'h0200);
        wr(5'h00, 5'h1f, 16'h0000);
        rd(5'h05, 5'h1f, 17'h02000);
        wr(5'h05, 5'h1f, 16'h0000);
        @(posedge clk_i);
        #1 partner_mdix_i = 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(swp, 1'b0, "auto follows partner")
        wr(5'h05, 5'h1b, 16'h0300);
        ev(8'h04);
        `CHK(ipin, 1'b1, "masked condition")
        ev(8'h01);
        `CHK(ipin, 1'b0, "enabled condition")
        rd(5'h05, 5'h1b, 17'h00305);
        `CHK(ipin, 1'b1, "cleared by read")
        rd(5'h05, 5'h1b, 17'h00300);
        wr(5'h05, 5'h1f, 16'h0200);
        `CHK(ipin, 1'b0, "active high idle")
        wr(5'h05, 5'h00, 16'h4100);
        `CHK({lloop, spd}, 2'b10, "local loop at 10")
        wr(5'h05, 5'h00, 16'h2100);
        wr(5'h05, 5'h1f, 16'h0004);
        `CHK({lloop, rloop}, 2'b01, "remote loop")
        wr(5'h05, 5'h00, 16'h2000);
        `CHK(rloop, 1'b0, "remote loop half duplex")
        `CHK(fdx, 1'b0, "half duplex selected")
        @(posedge clk_i);
        #1 srst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK({ipin, fdx, spd}, 3'b111, "outputs after reset")
        rd(5'h05, 5'h1f, 17'h00000);
        end_sim;
    end
endmodule
